// >>> opt_cfg.svh
`ifndef OPT_CFG_SVH
`define OPT_CFG_SVH
`define OPT_ADDR_W 8
`define OPT_DATA_W 32
`define OPT_CNT_W 24
`define OPT_FLAG_W 11
`define OPT_PROTO_TMR_OFS 8'h6a
`define OPT_ELAPSED_TMR_OFS 8'h6c
`define OPT_IRQ_STATUS_OFS 8'h70
`define OPT_IRQ_ENABLE_OFS 8'h71
`define OPT_IRQ_CLEAR_OFS 8'h72
`define OPT_RUN_BIT 31
`define OPT_CNT_MSB 23
`define OPT_TIMEOUT_BIT 10
`define OPT_CTRL_RST 32'h0000_0000
`define OPT_TICK_NS 10000
`define OPT_CLK_NS 4
`define OPT_TICK_CYC (`OPT_TICK_NS / `OPT_CLK_NS)
`define OPT_IRQ_W 3
`define OPT_IRQ_TIMEOUT 0
`define OPT_IRQ_SATURATE 1
`define OPT_IRQ_EVENT_STOP 2
`endif

// >>> opt_pkg.sv
package opt_pkg;
  typedef logic [23:0] opt_cnt_t;
  typedef enum logic [1:0] {
    OPT_IDLE,
    OPT_RUN
  } opt_run_e;
endpackage

// >>> opt_prescaler.sv
`timescale 1ns/1ps
`include "opt_cfg.svh"
module opt_prescaler (
  input wire logic sys_clk,
  input wire logic rst,
  output logic tick
);
  import opt_pkg::*;
  localparam int unsigned TICK_CYC = `OPT_TICK_CYC;
  logic [11:0] div_q;
  logic [11:0] div_d;
  logic wrap;
  assign wrap = (div_q == 12'(TICK_CYC - 1));
  assign div_d = wrap ? 12'h000 : div_q + 12'h001;
  // One cycle pulse every 10 us
  assign tick = wrap;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      div_q <= 12'h000;
    end else begin
      div_q <= div_d;
    end
  end
endmodule

// >>> opt_irq.sv
`timescale 1ns/1ps
`include "opt_cfg.svh"
module opt_irq (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [`OPT_IRQ_W-1:0] event_set,
  input wire logic [`OPT_IRQ_W-1:0] clear_mask,
  input wire logic clear_we,
  input wire logic [`OPT_IRQ_W-1:0] enable,
  output logic [`OPT_IRQ_W-1:0] status,
  output logic irq
);
  import opt_pkg::*;
  logic [`OPT_IRQ_W-1:0] stat_q;
  logic [`OPT_IRQ_W-1:0] stat_d;
  genvar i;
  // Set wins over a clear in the same cycle
  generate
    for (i = 0; i < `OPT_IRQ_W; i++) begin : g_bit
      assign stat_d[i] = event_set[i] | (stat_q[i] & ~(clear_we & clear_mask[i]));
    end
  endgenerate
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      stat_q <= '0;
    end else begin
      stat_q <= stat_d;
    end
  end
  assign status = stat_q;
  assign irq = |(stat_q & enable);
endmodule

// >>> opt_timers.sv
// Added by the designer: strobed register access.
`timescale 1ns/1ps
`include "opt_cfg.svh"
module opt_timers (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [`OPT_ADDR_W-1:0] reg_addr,
  input wire logic [`OPT_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [`OPT_DATA_W-1:0] reg_rdata,
  input wire logic [`OPT_FLAG_W-1:0] dual_role_event_flags,
  input wire logic [`OPT_FLAG_W-1:0] dual_role_event_enables,
  output logic timeout_event,
  output logic timeout_irq,
  output logic irq
);
  import opt_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers for the event flags and enables
  logic [`OPT_FLAG_W-1:0] flg_meta_q;
  logic [`OPT_FLAG_W-1:0] flg_q;
  logic [`OPT_FLAG_W-1:0] ena_meta_q;
  logic [`OPT_FLAG_W-1:0] ena_q;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      flg_meta_q <= '0;
      flg_q <= '0;
      ena_meta_q <= '0;
      ena_q <= '0;
    end else begin
      flg_meta_q <= dual_role_event_flags;
      flg_q <= flg_meta_q;
      ena_meta_q <= dual_role_event_enables;
      ena_q <= ena_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Tick source
  logic tick;
  opt_prescaler u_pre (
    .sys_clk(sys_clk),
    .rst(rst),
    .tick(tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register decode
  function automatic logic hit(input logic [`OPT_ADDR_W-1:0] a, input logic [`OPT_ADDR_W-1:0] o);
    return a == o;
  endfunction
  wire wr_t1 = reg_wr & hit(reg_addr, `OPT_PROTO_TMR_OFS);
  wire wr_t2 = reg_wr & hit(reg_addr, `OPT_ELAPSED_TMR_OFS);
  wire wr_ien = reg_wr & hit(reg_addr, `OPT_IRQ_ENABLE_OFS);
  wire wr_iclr = reg_wr & hit(reg_addr, `OPT_IRQ_CLEAR_OFS);
  wire wr_run = reg_wdata[`OPT_RUN_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Timer one: time-out after reload_count ticks, elapsed count runs up from zero
  opt_run_e t1_st_q;
  opt_run_e t1_st_d;
  opt_cnt_t reload_count_q;
  opt_cnt_t reload_count_d;
  opt_cnt_t t1_elap_q;
  opt_cnt_t t1_elap_d;
  logic t1_done;
  // Bits 23..0 hold the reload count
  assign reload_count_d = wr_t1 ? reg_wdata[`OPT_CNT_MSB:0] : reload_count_q;
  // Elapsed equals reload: time-out; zero reload expires on first tick
  assign t1_done = (t1_st_q == OPT_RUN) & tick &
                   ((t1_elap_q + 24'h000001) >= reload_count_q);
  always_comb begin
    t1_st_d = t1_st_q;
    t1_elap_d = t1_elap_q;
    unique case (t1_st_q)
      OPT_IDLE: begin
        if (wr_t1 && wr_run) begin
          t1_st_d = OPT_RUN;
          t1_elap_d = 24'h000000; // Clear elapsed count to zero
        end
      end
      OPT_RUN: begin
        if (wr_t1 && !wr_run) begin
          t1_st_d = OPT_IDLE;
        end else if (wr_t1 && wr_run) begin
          t1_elap_d = 24'h000000; // Restart with new count
        end else if (t1_done) begin
          t1_st_d = OPT_IDLE; // Self clear of run bit
          t1_elap_d = t1_elap_q + 24'h000001;
        end else if (tick) begin
          t1_elap_d = t1_elap_q + 24'h000001;
        end
      end
    endcase
  end
  wire t1_expire = t1_done & ~wr_t1;
  // One-cycle event at time-out
  assign timeout_event = t1_expire;

  ////////////////////////////////////////////////////////////////////////////
  // Timer two: elapsed up-counter
  opt_run_e t2_st_q;
  opt_run_e t2_st_d;
  opt_cnt_t t2_cnt_q;
  opt_cnt_t t2_cnt_d;
  opt_cnt_t t2_cap_q;
  opt_cnt_t t2_cap_d;
  logic ev_hit;
  logic t2_sat;
  // Sync'd flags and enables, two cycles behind the pins; a sampled pulse on an enabled flag stops the count
  assign ev_hit = |(flg_q & ena_q);
  assign t2_sat = (t2_cnt_q == 24'hff_ffff);
  always_comb begin
    t2_st_d = t2_st_q;
    t2_cnt_d = t2_cnt_q;
    t2_cap_d = t2_cap_q;
    unique case (t2_st_q)
      OPT_IDLE: begin
        if (wr_t2 && wr_run) begin
          t2_st_d = OPT_RUN;
          t2_cnt_d = 24'h000000;
          // Old capture would otherwise hide the live count
          t2_cap_d = 24'h000000;
        end
      end
      OPT_RUN: begin
        if (wr_t2 && !wr_run) begin
          t2_st_d = OPT_IDLE;
        end else if (wr_t2 && wr_run) begin
          t2_cnt_d = 24'h000000;
          t2_cap_d = 24'h000000;
        end else if (ev_hit) begin
          t2_st_d = OPT_IDLE;
          t2_cap_d = t2_cnt_q;
        end else if (t2_sat) begin
          t2_st_d = OPT_IDLE; // Hold at all ones
        end else if (tick) begin
          t2_cnt_d = t2_cnt_q + 24'h000001;
        end
      end
    endcase
  end
  wire t2_sat_stop = (t2_st_q == OPT_RUN) & t2_sat & ~ev_hit & ~wr_t2;
  wire t2_ev_stop = (t2_st_q == OPT_RUN) & ev_hit & ~wr_t2;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      t1_st_q <= OPT_IDLE;
      t1_elap_q <= '0;
      reload_count_q <= '0;
      t2_st_q <= OPT_IDLE;
      t2_cnt_q <= '0;
      t2_cap_q <= '0;
    end else begin
      t1_st_q <= t1_st_d;
      t1_elap_q <= t1_elap_d;
      reload_count_q <= reload_count_d;
      t2_st_q <= t2_st_d;
      t2_cnt_q <= t2_cnt_d;
      t2_cap_q <= t2_cap_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts
  logic [`OPT_IRQ_W-1:0] ien_q;
  logic [`OPT_IRQ_W-1:0] ev_vec;
  logic [`OPT_IRQ_W-1:0] istat;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ien_q <= '0;
    end else if (wr_ien) begin
      ien_q <= reg_wdata[`OPT_IRQ_W-1:0];
    end
  end
  assign ev_vec[`OPT_IRQ_TIMEOUT] = t1_expire;
  assign ev_vec[`OPT_IRQ_SATURATE] = t2_sat_stop;
  assign ev_vec[`OPT_IRQ_EVENT_STOP] = t2_ev_stop;
  opt_irq u_irq (
    .sys_clk(sys_clk),
    .rst(rst),
    .event_set(ev_vec),
    .clear_mask(reg_wdata[`OPT_IRQ_W-1:0]),
    .clear_we(wr_iclr),
    .enable(ien_q),
    .status(istat),
    .irq(irq)
  );
  // Timeout request gated by the dual-role enable bit
  assign timeout_irq = istat[`OPT_IRQ_TIMEOUT] & ena_q[`OPT_TIMEOUT_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Read path, one cycle latency; unmapped reads return zero
  logic [`OPT_DATA_W-1:0] rsel;
  logic [`OPT_DATA_W-1:0] rdata_q;
  always_comb begin
    rsel = '0;
    if (hit(reg_addr, `OPT_PROTO_TMR_OFS)) begin
      rsel = {(t1_st_q == OPT_RUN), 7'h00, reload_count_q};
    end else if (hit(reg_addr, `OPT_ELAPSED_TMR_OFS)) begin
      // Live count while running, frozen capture after an event
      rsel = {(t2_st_q == OPT_RUN), 7'h00, t2_cap_q == 24'h0 ? t2_cnt_q : t2_cap_q};
    end else if (hit(reg_addr, `OPT_IRQ_STATUS_OFS)) begin
      rsel = {29'h0, istat};
    end else if (hit(reg_addr, `OPT_IRQ_ENABLE_OFS)) begin
      rsel = {29'h0, ien_q};
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= reg_rd ? rsel : 32'h0000_0000;
    end
  end
  assign reg_rdata = rdata_q;
endmodule

// >>> opt_timers_chk.sv
`timescale 1ns/1ps
`include "opt_cfg.svh"
module opt_timers_chk (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [`OPT_ADDR_W-1:0] reg_addr,
  input wire logic [`OPT_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [`OPT_DATA_W-1:0] reg_rdata,
  input wire logic [`OPT_FLAG_W-1:0] dual_role_event_flags,
  input wire logic [`OPT_FLAG_W-1:0] dual_role_event_enables,
  input wire logic timeout_event,
  input wire logic timeout_irq,
  input wire logic irq
);
  import opt_pkg::*;
  // Cycles since last time-out, saturating so the first one always passes
  logic [11:0] gap_q;
  always_ff @(posedge sys_clk) begin
    if (rst) gap_q <= 12'hfff;
    else if (timeout_event) gap_q <= 12'h000;
    else if (gap_q != 12'hfff) gap_q <= gap_q + 12'h001;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_cfg_wr;
    reg_wr && reg_addr == 8'h6a && !reg_wdata[31];
  endsequence
  sequence s_cfg_rd;
    reg_rd && reg_addr == 8'h6a;
  endsequence
  property p_cfg_back;
    s_cfg_wr ##1 s_cfg_rd |=> reg_rdata == {8'h00, $past(reg_wdata[23:0], 2)};
  endproperty
  property p_start;
    reg_wr && reg_addr == 8'h6a && reg_wdata[31] && reg_wdata[23:0] > 24'h000001
      ##1 s_cfg_rd |=> reg_rdata[31];
  endproperty
  property p_stop;
    s_cfg_wr |=> !timeout_event [*2];
  endproperty
  property p_rd_quiet;
    !$past(reg_rd) |-> reg_rdata == 32'h0000_0000;
  endproperty
  property p_one_shot;
    timeout_event |=> !timeout_event;
  endproperty
  property p_gap;
    timeout_event |-> gap_q >= 12'h9c3;
  endproperty
  property p_irq_en;
    timeout_event && dual_role_event_enables[10] && $past(dual_role_event_enables[10])
      && $past(dual_role_event_enables[10], 2) && $past(dual_role_event_enables[10], 3)
      |=> timeout_irq;
  endproperty
  property p_irq_mask;
    !dual_role_event_enables[10] && !$past(dual_role_event_enables[10])
      && !$past(dual_role_event_enables[10], 2) && !$past(dual_role_event_enables[10], 3)
      |-> !timeout_irq;
  endproperty
  property p_reset_quiet;
    $fell(rst) |-> !irq && !timeout_irq;
  endproperty
  a_cfg_back: assert property (p_cfg_back) else $error("reload readback wrong");
  a_start: assert property (p_start) else $error("run bit not set");
  a_stop: assert property (p_stop) else $error("time-out after stop");
  a_rd_quiet: assert property (p_rd_quiet) else $error("read data not zero");
  a_one_shot: assert property (p_one_shot) else $error("time-out repeated");
  a_gap: assert property (p_gap) else $error("time-outs too close");
  a_irq_en: assert property (p_irq_en) else $error("time-out irq missing");
  a_irq_mask: assert property (p_irq_mask) else $error("masked irq raised");
  a_reset_quiet: assert property (p_reset_quiet) else $error("irq after reset");
endmodule
bind opt_timers opt_timers_chk opt_timers_chk_inst (.sys_clk(sys_clk), .rst(rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .dual_role_event_flags(dual_role_event_flags),
  .dual_role_event_enables(dual_role_event_enables), .timeout_event(timeout_event),
  .timeout_irq(timeout_irq), .irq(irq));

// >>> opt_timers_tb.sv
`timescale 1ns/1ps
`include "opt_cfg.svh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fail_count++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module opt_timers_tb;
  import opt_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [10:0] flags = 11'h000;
  logic [10:0] ens = 11'h000;
  logic timeout_event;
  logic timeout_irq;
  logic irq;
  int fail_count = 0;
  int check_count = 0;
  int n;
  int r;
  logic [31:0] v;
  logic [31:0] w;
  initial begin
    forever #2 sys_clk = ~sys_clk;
  end
  opt_timers opt_timers_inst (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .dual_role_event_flags(flags), .dual_role_event_enables(ens),
    .timeout_event(timeout_event), .timeout_irq(timeout_irq), .irq(irq));
  ////////////////////////////////////////////////////////////////////////////////
  // Tick phase is free running, so either neighbouring count is legal
  function automatic logic ticks_ok(input int cycles, input int k);
    return k == cycles / `OPT_TICK_CYC || k == cycles / `OPT_TICK_CYC + 1;
  endfunction
  task report_and_stop;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task cyc(input int k);
    repeat (k) @(posedge sys_clk);
  endtask
  // Bus tasks are entered right after a rising edge
  task wr(input logic [7:0] a, input logic [31:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] d);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    d = reg_rdata;
    @(posedge sys_clk);
  endtask
  task wait_ev;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (timeout_event !== 1'b1 && n < 5 * `OPT_TICK_CYC);
    if (n >= 5 * `OPT_TICK_CYC) begin
      fail_count++;
      report_and_stop;
    end
    @(posedge sys_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    v = $urandom(36);
    cyc(4);
    rst <= 1'b0;
    cyc(2);
    rd(8'h6a, v); `CHK(v, 32'h0000_0000)
    rd(8'h6c, v); `CHK(v, 32'h0000_0000)
    rd(8'h55, v); `CHK(v, 32'h0000_0000)
    w = $urandom & 32'h7fff_ffff;
    wr(8'h6a, w);
    rd(8'h6a, v); `CHK(v, w & 32'h00ff_ffff)
    wr(8'h71, 32'h0000_0007);
    $display("reset and config test done");
    for (int e = 1; e >= 0; e--) begin
      ens <= {e[0], 10'h000};
      r = $urandom_range(4, 2);
      wr(8'h6a, 32'h8000_0000 | r);
      rd(8'h6a, v); `CHK(v[31], 1'b1)
      wait_ev();
      `CHK(ticks_ok(n + 3, r), 1'b1)
      cyc(3);
      `CHK(timeout_irq, e[0])
      `CHK(irq, 1'b1)
      rd(8'h6a, v); `CHK(v[31], 1'b0)
      rd(8'h70, v); `CHK(v[0], 1'b1)
      wr(8'h72, 32'h0000_0001);
      rd(8'h70, v); `CHK(v[0], 1'b0)
      `CHK(irq, 1'b0)
      $display("timer one test done");
    end
    wr(8'h6a, 32'h8000_0002);
    cyc(5);
    wr(8'h6a, 32'h0000_0002);
    n = 0;
    repeat (6000) begin
      @(negedge sys_clk);
      if (timeout_event === 1'b1) n++;
    end
    `CHK(n, 0)
    $display("timer one stop test done");
    @(posedge sys_clk);
    ens <= 11'h008;
    wr(8'h6c, 32'h8000_0000);
    cyc(7000);
    rd(8'h6c, v); `CHK(v[31], 1'b1)
    `CHK(ticks_ok(7002, v[23:0]), 1'b1)
    wr(8'h6c, 32'h0000_0000);
    rd(8'h6c, v);
    cyc(3000);
    rd(8'h6c, w); `CHK(w, v)
    wr(8'h6c, 32'h8000_0000);
    cyc(3000);
    flags <= 11'h008;
    cyc(10);
    rd(8'h6c, v); `CHK(v[31], 1'b0)
    `CHK(ticks_ok(3004, v[23:0]), 1'b1)
    cyc(3000);
    rd(8'h6c, w); `CHK(w, v)
    rd(8'h70, v); `CHK(v[2], 1'b1)
    `CHK(irq, 1'b1)
    flags <= 11'h000;
    $display("timer two test done");
    report_and_stop;
  end
endmodule
